// [rtl/pmp_map.vh]
// Constants for the PHY management poller: frame layout, PHY register
// addresses and fields, option and port configuration fields, MDC timing.
// Assumes a 10 MHz ref_clk and standard clause-22 PHY registers.
`ifndef PMP_MAP_VH
`define PMP_MAP_VH

`define PMP_CLK_HZ          10000000
`define PMP_MDC_HALF_NS     400
`define PMP_CLK_NS          100
`define PMP_MDC_SLOW_HZ     17000

`define PMP_PREAMBLE        32'hFFFFFFFF
`define PMP_SOF             2'h1
`define PMP_OP_WRITE        2'h1
`define PMP_OP_READ         2'h2
`define PMP_TA_WRITE        2'h2
`define PMP_TA_FIRST_BIT    6'h2E
`define PMP_TA_ZERO_BIT     6'h2F
`define PMP_LAST_BIT        6'h3F

`define PMP_OPTIONS_OFFSET  5'h05
`define PMP_OPT_SLOW_BIT    0
`define PMP_OPT_ADDR8_BIT   1
`define PMP_OPT_DESC_BIT    2
`define PMP_OPT_VREG_LSB    8
`define PMP_ADDR_BASE       5'h08

`define PMP_CFG_SPD_BIT     0
`define PMP_CFG_DPX_BIT     1
`define PMP_CFG_PAUSE_BIT   2
`define PMP_CFG_FORCE_BIT   3
`define PMP_CFG_CAP_LSB     4

`define PMP_REG_CTRL        5'h00
`define PMP_REG_STAT        5'h01
`define PMP_REG_ADV         5'h04
`define PMP_REG_LPA         5'h05
`define PMP_CTRL_SPD_BIT    13
`define PMP_CTRL_AN_BIT     12
`define PMP_CTRL_DPX_BIT    8
`define PMP_STAT_LINK_BIT   2
`define PMP_STAT_ANDONE_BIT 5
`define PMP_ADV_SELECTOR    5'h01
`define PMP_ADV_CAP_LSB     5
`define PMP_ADV_PAUSE_BIT   10
`define PMP_VND_SPD_BIT     1
`define PMP_VND_DPX_BIT     0

`endif

// [rtl/pmp_mdio_frame.v]
// One management frame engine: makes MDC, shifts a 64-bit frame out on
// MDIO and, for reads, releases the line and shifts 16 bits back in.
// Assumes start is only raised while busy_r is low.
`timescale 1ns/1ps
`include "pmp_map.vh"

module pmp_mdio_frame (
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        start,
	input  wire        isRead,
	input  wire        slowClk,
	input  wire [4:0]  phyAddr,
	input  wire [4:0]  regAddr,
	input  wire [15:0] wrData,
	input  wire        mdioIn,
	output reg         mdc_r,
	output reg         mdioOut_r,
	output reg         mdioOe_r,
	output reg         busy_r,
	output reg         done_r,
	output reg         rdOk_r,
	output reg  [15:0] rdData_r
);
	localparam integer FAST_I    = `PMP_MDC_HALF_NS / `PMP_CLK_NS;
	localparam integer SLOW_I    = `PMP_CLK_HZ / (2 * `PMP_MDC_SLOW_HZ);
	localparam [8:0]   FAST_HALF = FAST_I[8:0];
	localparam [8:0]   SLOW_HALF = SLOW_I[8:0];

	reg  [8:0]  div_r;
	reg  [5:0]  bitIdx_r;
	reg  [63:0] frame_r;
	reg         isRead_r;
	reg         sync1_r;
	reg         sync2_r;
	wire [8:0]  halfCnt = slowClk ? SLOW_HALF : FAST_HALF;
	wire        tick    = busy_r && (div_r >= halfCnt - 9'h001);
	wire [5:0]  nextIdx = bitIdx_r + 6'h01;

	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			div_r     <= 9'h000;
			bitIdx_r  <= 6'h00;
			frame_r   <= 64'h0;
			isRead_r  <= 1'b0;
			sync1_r   <= 1'b0;
			sync2_r   <= 1'b0;
			mdc_r     <= 1'b0;
			mdioOut_r <= 1'b0;
			mdioOe_r  <= 1'b0;
			busy_r    <= 1'b0;
			done_r    <= 1'b0;
			rdOk_r    <= 1'b0;
			rdData_r  <= 16'h0000;
		end
		else
		begin
			sync1_r <= mdioIn;
			sync2_r <= sync1_r;
			done_r  <= 1'b0;
			if (!busy_r)
			begin
				if (start)
				begin
					// Preamble and start pattern lead every frame
					frame_r <= {`PMP_PREAMBLE, `PMP_SOF,
						isRead ? `PMP_OP_READ : `PMP_OP_WRITE, phyAddr, regAddr,
						isRead ? 2'h3 : `PMP_TA_WRITE, isRead ? 16'h0000 : wrData};
					busy_r    <= 1'b1;
					isRead_r  <= isRead;
					bitIdx_r  <= 6'h00;
					div_r     <= 9'h000;
					mdioOut_r <= 1'b1;
					mdioOe_r  <= 1'b1;
					rdOk_r    <= 1'b0;
					rdData_r  <= 16'h0000;
				end
			end
			else
			begin
				div_r <= tick ? 9'h000 : div_r + 9'h001;
				if (tick)
				begin
					mdc_r <= ~mdc_r;
					if (!mdc_r)
					begin
						// Rising edge: PHY changed data after the previous fall
						if (isRead_r && bitIdx_r == `PMP_TA_ZERO_BIT)
							rdOk_r <= ~sync2_r;
						if (isRead_r && bitIdx_r > `PMP_TA_ZERO_BIT)
							rdData_r <= {rdData_r[14:0], sync2_r};
					end
					else if (bitIdx_r == `PMP_LAST_BIT)
					begin
						busy_r    <= 1'b0;
						mdioOe_r  <= 1'b0;
						mdioOut_r <= 1'b0;
						done_r    <= 1'b1;
					end
					else
					begin
						// Falling edge: new bit, half a period before the PHY samples
						bitIdx_r  <= nextIdx;
						mdioOut_r <= frame_r[62];
						frame_r   <= {frame_r[62:0], 1'b0};
						mdioOe_r  <= !(isRead_r && nextIdx >= `PMP_TA_FIRST_BIT);
					end
				end
			end
		end
	end
endmodule // pmp_mdio_frame

// [rtl/pmp_poller.v]
// PHY management poller: walks the ports, programs PHYs in master mode or with nonAutoNeg set,
// polls status and resolves each port's link, speed and duplex.
// Assumes configuration inputs are steady levels on ref_clk; mdioIn is a pin.
`timescale 1ns/1ps
`include "pmp_map.vh"

module pmp_poller #(
	parameter NPORT = 8
) (
	input  wire                 ref_clk,
	input  wire                 rst_n,
	input  wire                 masterMode,
	input  wire                 nonAutoNeg,
	input  wire                 mgmtDisable,
	input  wire [15:0]          phyAccessOptions,
	input  wire [NPORT*8-1:0]   portCfg,
	input  wire                 mdioIn,
	output wire                 mdc,
	output wire                 mdioOut,
	output wire                 mdioOe,
	output reg  [NPORT-1:0]     portLink_r,
	output reg  [NPORT-1:0]     portSpeed100_r,
	output reg  [NPORT-1:0]     portFullDuplex_r
);
	localparam PW = (NPORT > 1) ? $clog2(NPORT) : 1;
	// Highest port index, cut to the widths it is compared against
	localparam integer  LAST_I    = NPORT - 1;
	localparam [PW-1:0] LAST_PORT = LAST_I[PW-1:0];
	localparam [4:0]    LAST_ADDR = LAST_I[4:0];

	localparam [6:0] S_SEL   = 7'h01;
	localparam [6:0] S_WCAP  = 7'h02;
	localparam [6:0] S_WCTL  = 7'h04;
	localparam [6:0] S_RSTAT = 7'h08;
	localparam [6:0] S_RLP   = 7'h10;
	localparam [6:0] S_RVND  = 7'h20;
	localparam [6:0] S_UPD   = 7'h40;

	reg  [6:0]    state_r;
	reg  [6:0]    state_nxt;
	reg  [PW-1:0] port_r;
	reg           issued_r;
	reg           readOk_r;
	reg  [15:0]   stat_r;
	reg  [15:0]   lpa_r;
	reg  [15:0]   vnd_r;
	reg  [PW-1:0] port_nxt;
	reg           link_nxt;
	reg           spd_nxt;
	reg           dpx_nxt;

	reg           opRead;
	reg  [4:0]    opReg;
	reg  [15:0]   opData;
	wire          opBusy;
	wire          opDone;
	wire          opRdOk;
	wire [15:0]   opRdData;

	wire [7:0]    cfg       = portCfg[{{(8-PW){1'b0}}, port_r} * 8 +: 8];
	wire [3:0]    cap       = cfg[`PMP_CFG_CAP_LSB +: 4];
	wire          forceMode = masterMode && !nonAutoNeg && cfg[`PMP_CFG_FORCE_BIT];
	wire [4:0]    vndReg    = phyAccessOptions[`PMP_OPT_VREG_LSB +: 5];
	wire [4:0]    port5     = {{(5-PW){1'b0}}, port_r};
	wire [4:0]    idx5      = phyAccessOptions[`PMP_OPT_DESC_BIT] ? LAST_ADDR - port5 : port5;
	wire [4:0]    phyAddr   = phyAccessOptions[`PMP_OPT_ADDR8_BIT] ? idx5 + `PMP_ADDR_BASE : idx5;
	wire          opState   = (state_r != S_SEL) && (state_r != S_UPD);
	wire          opStart   = opState && !issued_r && !opBusy;
	wire          skipPort  = mgmtDisable && (port_r == {PW{1'b0}});

	// In slave mode our own advertisement is unknown, so any partner ability counts
	wire [3:0]    common    = lpa_r[`PMP_ADV_CAP_LSB +: 4] & (masterMode ? cap : 4'hF);
	wire          anOk      = stat_r[`PMP_STAT_ANDONE_BIT] && (common != 4'h0);
	wire          linkUp    = readOk_r && stat_r[`PMP_STAT_LINK_BIT];

	pmp_mdio_frame u_frame (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.start     (opStart),
		.isRead    (opRead),
		.slowClk   (phyAccessOptions[`PMP_OPT_SLOW_BIT]),
		.phyAddr   (phyAddr),
		.regAddr   (opReg),
		.wrData    (opData),
		.mdioIn    (mdioIn),
		.mdc_r     (mdc),
		.mdioOut_r (mdioOut),
		.mdioOe_r  (mdioOe),
		.busy_r    (opBusy),
		.done_r    (opDone),
		.rdOk_r    (opRdOk),
		.rdData_r  (opRdData)
	);

	// Frame contents for the current step
	always @*
	begin
		opRead = 1'b1;
		opReg  = `PMP_REG_STAT;
		opData = 16'h0000;
		case (state_r)
			S_WCAP:
			begin
				opRead = 1'b0;
				opReg  = `PMP_REG_ADV;
				opData[4:0] = `PMP_ADV_SELECTOR;
				opData[`PMP_ADV_CAP_LSB +: 4] = cap;
				opData[`PMP_ADV_PAUSE_BIT] = cfg[`PMP_CFG_PAUSE_BIT];
			end
			S_WCTL:
			begin
				// Negotiation off; speed and duplex bits only matter when forcing
				opRead = 1'b0;
				opReg  = `PMP_REG_CTRL;
				opData[`PMP_CTRL_AN_BIT]  = 1'b0;
				opData[`PMP_CTRL_SPD_BIT] = forceMode & cfg[`PMP_CFG_SPD_BIT];
				opData[`PMP_CTRL_DPX_BIT] = forceMode & cfg[`PMP_CFG_DPX_BIT];
			end
			S_RSTAT:
				opReg = `PMP_REG_STAT;
			S_RLP:
				opReg = `PMP_REG_LPA;
			S_RVND:
				opReg = vndReg;
			default:
				opReg = `PMP_REG_STAT;
		endcase
	end

	// Step order for one port
	always @*
	begin
		state_nxt = state_r;
		port_nxt  = port_r;
		case (state_r)
			S_SEL:
			begin
				if (skipPort)
					state_nxt = S_UPD;
				else if (masterMode && !nonAutoNeg && !forceMode)
					state_nxt = S_WCAP;
				else if (nonAutoNeg || forceMode)
					state_nxt = S_WCTL;
				else
					state_nxt = S_RSTAT;
			end
			S_WCAP:
				if (opDone) state_nxt = S_RSTAT;
			S_WCTL:
				if (opDone) state_nxt = S_RSTAT;
			S_RSTAT:
				if (opDone) state_nxt = S_RLP;
			S_RLP:
				if (opDone) state_nxt = (vndReg != 5'h00) ? S_RVND : S_UPD;
			S_RVND:
				if (opDone) state_nxt = S_UPD;
			S_UPD:
			begin
				state_nxt = S_SEL;
				if (port_r == LAST_PORT)
					port_nxt = {PW{1'b0}};
				else
					port_nxt = port_r + {{(PW-1){1'b0}}, 1'b1};
			end
			default:
				state_nxt = S_SEL;
		endcase
	end

	// Walk of steps and ports
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state_r <= S_SEL;
			port_r  <= {PW{1'b0}};
		end
		else
		begin
			state_r <= state_nxt;
			port_r  <= port_nxt;
		end
	end

	// Frame issue and read results; one frame per step, so a late done cannot re-arm it
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			issued_r <= 1'b0;
			readOk_r <= 1'b0;
			stat_r   <= 16'h0000;
			lpa_r    <= 16'h0000;
			vnd_r    <= 16'h0000;
		end
		else
		begin
			if (opStart)
				issued_r <= 1'b1;
			else if (opDone)
				issued_r <= 1'b0;
			if (state_r == S_SEL)
			begin
				readOk_r <= 1'b1;
				vnd_r    <= 16'h0000;
			end
			if (opDone && opRead)
				readOk_r <= readOk_r & opRdOk; // A silent PHY reads as link down
			if (opDone && state_r == S_RSTAT)
				stat_r <= opRdData;
			if (opDone && state_r == S_RLP)
				lpa_r <= opRdData;
			if (opDone && state_r == S_RVND)
				vnd_r <= opRdData;
		end
	end

	// Resolved status of the port being walked, taken in its update step
	always @*
	begin
		link_nxt = linkUp;
		spd_nxt  = cfg[`PMP_CFG_SPD_BIT];
		dpx_nxt  = cfg[`PMP_CFG_DPX_BIT];
		if (skipPort)
		begin
			// No management access: the configured mode stands as an up link
			link_nxt = 1'b1;
			spd_nxt  = cfg[`PMP_CFG_SPD_BIT];
			dpx_nxt  = cfg[`PMP_CFG_DPX_BIT];
		end
		else if (!linkUp || forceMode)
		begin
			spd_nxt = cfg[`PMP_CFG_SPD_BIT];
			dpx_nxt = cfg[`PMP_CFG_DPX_BIT];
		end
		else if (anOk)
		begin
			// Best common ability wins: 100FD, 100HD, 10FD, 10HD
			spd_nxt = common[3] | common[2];
			dpx_nxt = common[3] | (!common[2] & common[1]);
		end
		else if (vndReg != 5'h00)
		begin
			spd_nxt = vnd_r[`PMP_VND_SPD_BIT];
			dpx_nxt = vnd_r[`PMP_VND_DPX_BIT];
		end
		else
		begin
			spd_nxt = cfg[`PMP_CFG_SPD_BIT];
			dpx_nxt = cfg[`PMP_CFG_DPX_BIT];
		end
	end

	// One status slot per port; the others hold while a port is walked
	genvar g;
	generate
		for (g = 0; g < NPORT; g = g + 1)
		begin : g_port
			always @(posedge ref_clk)
			begin
				if (!rst_n)
				begin
					portLink_r[g]       <= 1'b0;
					portSpeed100_r[g]   <= 1'b0;
					portFullDuplex_r[g] <= 1'b0;
				end
				else if (state_r == S_UPD && port_r == g)
				begin
					portLink_r[g]       <= link_nxt;
					portSpeed100_r[g]   <= spd_nxt;
					portFullDuplex_r[g] <= dpx_nxt;
				end
			end
		end
	endgenerate
endmodule // pmp_poller

// [test/pmp_poller_monitor.sv]
// Checker for MDIO frame shape and MDC timing at the poller pins.
// Bit index counts MDC falls from the rise of the data enable.
`timescale 1ns/1ps
module pmp_poller_monitor (
	input wire        ref_clk,
	input wire        rst_n,
	input wire [15:0] phyAccessOptions,
	input wire        mdc,
	input wire        mdioOut,
	input wire        mdioOe
);
	reg        mdcQ_r;
	reg        oeQ_r;
	reg        act_r;
	reg        op_r;
	reg  [6:0] idx_r;
	wire       fall  = mdcQ_r & ~mdc;
	wire       start = mdioOe & ~oeQ_r & ~act_r;
	wire [6:0] cur   = act_r ? idx_r + {6'h00, fall} : 7'h00;
	wire       inFrm = (act_r | start) & (cur < 7'h40);
	// Out and enable move on the same edge as the MDC fall, so the index leads by that fall
	always @(posedge ref_clk)
	begin
		mdcQ_r <= rst_n & mdc;
		oeQ_r <= rst_n & mdioOe;
		act_r <= rst_n & (start | (act_r & (cur != 7'h40)));
		idx_r <= cur;
		op_r <= (inFrm && cur == 7'h22) ? mdioOut : op_r;
	end
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_highHalf;
		mdc [*4] ##1 !mdc;
	endsequence
	a_mdc_half: assert property ($rose(mdc) && !phyAccessOptions[0] |-> s_highHalf) else $error("mdc high time");
	a_preamble_ones: assert property (inFrm && cur < 7'h20 |-> mdioOe && mdioOut) else $error("preamble");
	a_start_bits: assert property (inFrm && (cur == 7'h20 || cur == 7'h21) |-> mdioOut == cur[0]) else $error("sof");
	a_opcode_pair: assert property (inFrm && cur == 7'h23 |-> mdioOe && mdioOut != op_r) else $error("opcode");
	a_write_turn: assert property (inFrm && !op_r && (cur == 7'h2E || cur == 7'h2F) |-> mdioOut != cur[0]) else $error("ta");
	a_write_drive: assert property (inFrm && !op_r && cur > 7'h22 |-> mdioOe) else $error("write release");
	a_read_release: assert property (inFrm && op_r && cur > 7'h2D |-> !mdioOe) else $error("read drive");
	a_frame_release: assert property (act_r && cur == 7'h40 |-> !mdioOe ##1 !mdioOe) else $error("end drive");
	a_out_steady: assert property (mdioOe && oeQ_r && !fall |-> $stable(mdioOut)) else $error("out moved");
endmodule // pmp_poller_monitor

bind pmp_poller pmp_poller_monitor u_pmp_poller_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
	.phyAccessOptions(phyAccessOptions), .mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe));

// [test/pmp_phy_model.sv]
// Behavioural PHYs on the management bus, registers held by {phy, reg}.
// Assumes mdio is the resolved wire, pulled up while nobody drives it.
`timescale 1ns/1ps
module pmp_phy_model (
	input  wire mdc,
	input  wire mdio,
	input  wire badTa,
	output reg  phyOut,
	output reg  phyOe
);
	reg  [15:0] mem [0:1023];
	reg  [31:0] acc = 32'h0;
	reg  [63:0] sr = 64'h0;
	reg  [16:0] sh = 17'h0;
	reg  [9:0]  addr = 10'h000;
	reg         inFrm = 1'b0;
	reg         rd = 1'b0;
	integer     cnt = 0;
	integer     nFrm = 0;
	integer     nWr = 0;
	integer     i;
	initial
	begin
		phyOe = 1'b0;
		phyOut = 1'b1;
		for (i = 0; i < 1024; i = i + 1)
			mem[i] = 16'h0000;
	end
	always @(posedge mdc)
	begin
		sr = {sr[62:0], mdio};
		if (!inFrm)
		begin
			cnt = 0;
			inFrm = (sr[33:0] == {32'hFFFFFFFF, 2'h1});
		end
		else
		begin
			cnt = cnt + 1;
			if (cnt == 12)
			begin
				addr = sr[9:0];
				rd = sr[11];
				acc[sr[9:5]] = 1'b1;
			end
			if (cnt == 30)
			begin
				if (!rd)
					mem[addr] = sr[15:0];
				nWr = nWr + (rd ? 0 : 1);
				nFrm = nFrm + 1;
				inFrm = 1'b0;
				sr = 64'h0;
			end
		end
	end
	// Drive only after the idle turnaround bit, on falls, well ahead of the next rise
	always @(negedge mdc)
	begin
		if (inFrm && rd && cnt == 13)
			sh = {badTa, mem[addr]};
		phyOe = inFrm && rd && cnt >= 13;
		phyOut = phyOe ? sh[16] : 1'b1;
		sh = {sh[15:0], 1'b0};
	end
endmodule // pmp_phy_model

// [test/testbench.sv]
// Self-checking bench: a two-port poller facing the behavioural PHYs.
// Assumes PHYs are strapped at addresses 0-1, or at 8-9 once the address options are set.
`timescale 1ns/1ps
module testbench;
	reg         ref_clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         masterMode = 1'b1;
	reg         nonAutoNeg = 1'b0;
	reg         mgmtDisable = 1'b0;
	reg         badTa = 1'b0;
	reg  [15:0] opts = 16'h0000;
	reg  [15:0] portCfg = 16'h0BF4;
	wire        mdc;
	wire        mdioOut;
	wire        mdioOe;
	wire        phyOut;
	wire        phyOe;
	wire [1:0]  link;
	wire [1:0]  spd;
	wire [1:0]  dpx;
	wire        mdio = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);
	integer     errTotal = 0;
	integer     checksDone = 0;
	integer     i;
	integer     w0;
	initial
		forever #50 ref_clk = ~ref_clk;
	pmp_poller #(.NPORT(2)) u_pmp_poller (.ref_clk(ref_clk), .rst_n(rst_n), .masterMode(masterMode),
		.nonAutoNeg(nonAutoNeg), .mgmtDisable(mgmtDisable), .phyAccessOptions(opts), .portCfg(portCfg),
		.mdioIn(mdio), .mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .portLink_r(link),
		.portSpeed100_r(spd), .portFullDuplex_r(dpx));
	pmp_phy_model u_pmp_phy_model (.mdc(mdc), .mdio(mdio), .badTa(badTa), .phyOut(phyOut), .phyOe(phyOe));
	task check(input string name, input [31:0] seen, input [31:0] exp);
	begin
		checksDone = checksDone + 1;
		if (seen !== exp)
		begin
			errTotal = errTotal + 1;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	end
	endtask
	task testDone;
	begin
		$display("checks %0d errors %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	task frames(input integer n);
		integer t0;
		integer k;
	begin
		t0 = u_pmp_phy_model.nFrm;
		for (k = 0; k < n * 700 && u_pmp_phy_model.nFrm < t0 + n; k = k + 1)
			@(posedge ref_clk);
		if (u_pmp_phy_model.nFrm < t0 + n)
		begin
			check("frame count", u_pmp_phy_model.nFrm, t0 + n);
			testDone;
		end
	end
	endtask
	task pr(input [4:0] p, input [4:0] r, input [15:0] v);
		u_pmp_phy_model.mem[{p, r}] = v;
	endtask
	function [15:0] gr(input [4:0] p, input [4:0] r);
		gr = u_pmp_phy_model.mem[{p, r}];
	endfunction
	initial
	begin
		repeat (3) @(posedge ref_clk);
		for (i = 0; i < 10; i = i + 1)
		begin
			pr(i[4:0], 5'h01, 16'h0024);
			pr(i[4:0], 5'h05, 16'h0100);
		end
		rst_n <= 1'b1;
		frames(16);
		check("adv0", gr(5'h00, 5'h04), 16'h05E1);
		check("ctl1", gr(5'h01, 5'h00), 16'h2100);
		check("status", {link, spd, dpx}, 6'h3F);
		masterMode <= 1'b0;
		opts <= 16'h0006;
		portCfg <= 16'hF0F4;
		pr(5'h09, 5'h05, 16'h0020);
		pr(5'h08, 5'h05, 16'h0080);
		frames(8);
		w0 = u_pmp_phy_model.nWr;
		u_pmp_phy_model.acc = 32'h0;
		frames(16);
		check("writes", u_pmp_phy_model.nWr - w0, 0);
		check("addrs", u_pmp_phy_model.acc, 32'h00000300);
		check("slave", {link, spd, dpx}, 6'h38);
		opts <= 16'h1006;
		for (i = 8; i < 10; i = i + 1)
			pr(i[4:0], 5'h01, 16'h0004);
		pr(5'h09, 5'h10, 16'h0003);
		pr(5'h08, 5'h10, 16'h0001);
		frames(16);
		check("vendor", {link, spd, dpx}, 6'h37);
		opts <= 16'h0006;
		portCfg <= 16'hF1F2;
		frames(16);
		check("fallback", {link, spd, dpx}, 6'h39);
		badTa <= 1'b1;
		frames(16);
		check("bad ta link", link, 2'b00);
		badTa <= 1'b0;
		masterMode <= 1'b1;
		nonAutoNeg <= 1'b1;
		opts <= 16'h0000;
		pr(5'h00, 5'h00, 16'h1000);
		pr(5'h01, 5'h00, 16'h1000);
		frames(16);
		check("an off", {gr(5'h00, 5'h00), gr(5'h01, 5'h00)}, 32'h0);
		nonAutoNeg <= 1'b0;
		mgmtDisable <= 1'b1;
		portCfg <= 16'hF0F3;
		pr(5'h00, 5'h05, 16'h0020);
		frames(4);
		u_pmp_phy_model.acc = 32'h0;
		frames(16);
		check("port0 silent", u_pmp_phy_model.acc[0], 1'b0);
		check("port0 mode", {spd[0], dpx[0]}, 2'b11);
		testDone;
	end
endmodule // testbench
